// File: core/dspsel_consts.vh
// Purpose: Shared codes and constants of the slice datapath selection logic.
// Assumes: Included by bare name from every design file of the block.
// Notes:   Definitions only.
`ifndef DSPSEL_CONSTS_VH
`define DSPSEL_CONSTS_VH

`define DSPSEL_SEL2_0         2'h0
`define DSPSEL_SEL2_1         2'h1
`define DSPSEL_SEL2_2         2'h2
`define DSPSEL_SEL2_3         2'h3

`define DSPSEL_PRE_ADD        2'h0
`define DSPSEL_PRE_A_MINUS_B  2'h1
`define DSPSEL_PRE_B_MINUS_A  2'h2

`define DSPSEL_MULA_SHIFT     18
`define DSPSEL_ADDB_SHIFT     17
`define DSPSEL_NARROW_CARRY   64
`define DSPSEL_WIDE_CARRY     48
`define DSPSEL_WIDE_LSB       45
`define DSPSEL_ZERO64         64'h0000_0000_0000_0000
`define DSPSEL_ZERO48         48'h0000_0000_0000
`define DSPSEL_ZERO27         27'h000_0000
`define DSPSEL_ZERO13         13'h0000

`endif

// File: core/dspsel_preadd.v
// Purpose: Pre-adder of the slice, add or subtract of two 27-bit operands.
// Assumes: Mode is a static configuration value.
// Notes:   The result wraps at 27 bits; callers limit the input range if needed.
`include "dspsel_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module dspsel_preadd
#(
  parameter [1:0] PREADD_MODE = `DSPSEL_PRE_ADD
)
(
  input  wire [26:0] op_a,
  input  wire [26:0] op_b,
  output reg  [26:0] result
);

  always @*
  begin
    case (PREADD_MODE)
      `DSPSEL_PRE_ADD:       result = op_a + op_b;
      `DSPSEL_PRE_A_MINUS_B: result = op_a - op_b;
      `DSPSEL_PRE_B_MINUS_A: result = op_b - op_a;
      default:               result = `DSPSEL_ZERO27;
    endcase
  end

endmodule

`default_nettype wire

// File: core/dspsel_top.v
// Purpose: Static datapath selection of a cascadable multiply-accumulate slice.
// Assumes: All selection parameters are fixed for the life of a configuration.
// Notes:   One clock; cascade inputs come from neighbouring slices on that clock.
//
// Contract
// - Reverse delay register takes reverse or own forward.
// - Multiplier A operand select, four codes.
// - Multiplier B operand select, four codes.
// - Bypass routes adder A operand to result.
// - Adder A codes 00/01: product, product shifted 18.
// - Adder A codes 10/11: concatenation, cascade input.
// - Adder B: registered result or cascade input.
// - Shift control shifts B right seventeen bits.
// - Carry-in from pin or lower slice carry.
// - Result select 00 gives adder bits 44:0.
// - Result select 01 gives adder bits 63:32.
// - Result select 10 gives reverse result low bits.
// - Narrow mode: flags on own pins, 64-bit carry.
// - Wide mode: flags become result bits 47:45.
// - Wide mode: carry-out from arithmetic bit 48.
// - Forward cascade output: unregistered, registered, passthrough.
// - Pre-adder adds or subtracts 27-bit operands.
`include "dspsel_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module dspsel_top
#(
  parameter [1:0]  PREADD_MODE   = `DSPSEL_PRE_ADD,
  parameter [1:0]  SEL_FWD_PRE   = `DSPSEL_SEL2_2,
  parameter [1:0]  SEL_REV_PRE   = `DSPSEL_SEL2_2,
  parameter        SEL_REVI_CASC = 1'b0,
  parameter [1:0]  SEL_MULT_A    = `DSPSEL_SEL2_0,
  parameter [1:0]  SEL_MULT_B    = `DSPSEL_SEL2_0,
  parameter        ADDSUB_BYPASS = 1'b0,
  parameter [1:0]  SEL_ADDSUB_A  = `DSPSEL_SEL2_0,
  parameter        SEL_ADDSUB_B  = 1'b0,
  parameter        SEL_CIN       = 1'b0,
  parameter [1:0]  SEL_DOUT      = `DSPSEL_SEL2_0,
  parameter        SEL_48_DOUT   = 1'b0,
  parameter [1:0]  SEL_FWDO_DOUT = `DSPSEL_SEL2_1,
  parameter [63:0] MATCH_PATTERN = `DSPSEL_ZERO64
)
(
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [17:0] a,
  input  wire [26:0] b,
  input  wire [2:0]  reg_addr,
  input  wire [26:0] regfile_dout,
  input  wire [26:0] fwdi_casc,
  input  wire [26:0] revi_casc,
  input  wire [63:0] fwdi_dout,
  input  wire        fwdi_cin,
  input  wire [31:0] revi_dout,
  input  wire        cin,
  input  wire        sub,
  input  wire        mshift,
  output reg  [47:0] dout,
  output reg         over_pos,
  output reg         over_neg,
  output reg         match,
  output reg         cout,
  output reg  [26:0] fwdo_casc,
  output reg  [26:0] revo_casc,
  output reg  [63:0] fwdo_dout,
  output reg  [63:0] result_reg
);

  // Sum of two 64-bit words and a carry, with the carry out on top.
  function [64:0] add65;
    input [63:0] x;
    input [63:0] y;
    input        c;
    begin
      add65 = {1'b0, x} + {1'b0, y} + {64'h0000_0000_0000_0000, c};
    end
  endfunction

  // Carry out of the low 48 bits of the same sum.
  function carry48;
    input [63:0] x;
    input [63:0] y;
    input        c;
    reg   [48:0] s;
    begin
      s = {1'b0, x[47:0]} + {1'b0, y[47:0]} + {48'h0000_0000_0000, c};
      carry48 = s[`DSPSEL_WIDE_CARRY];
    end
  endfunction

  reg  [26:0] pre_op_a;
  reg  [26:0] pre_op_b;
  wire [26:0] pre_out;
  reg  [18:0] mult_a;
  reg  [26:0] mult_b;
  wire [45:0] product;
  wire [63:0] product_ext;
  wire [47:0] concat_abr;
  reg  [63:0] addsub_a;
  reg  [63:0] addsub_b_sel;
  reg  [63:0] addsub_b;
  reg  [63:0] addsub_b_op;
  reg         carry_in;
  wire [64:0] sum65;
  reg  [63:0] addsub_res;
  wire        carry_full;
  wire        carry_wide;
  wire        ovf_pos;
  wire        ovf_neg;
  wire        pat_match;
  reg  [47:0] next_dout;
  reg         next_over_pos;
  reg         next_over_neg;
  reg         next_match;
  reg         next_cout;

  always @*
  begin
    case (SEL_REV_PRE)
      `DSPSEL_SEL2_1: pre_op_a = revi_casc;
      `DSPSEL_SEL2_2: pre_op_a = {{9{a[17]}}, a};
      default:        pre_op_a = `DSPSEL_ZERO27;
    endcase
  end

  always @*
  begin
    case (SEL_FWD_PRE)
      `DSPSEL_SEL2_1: pre_op_b = fwdi_casc;
      `DSPSEL_SEL2_2: pre_op_b = b;
      default:        pre_op_b = `DSPSEL_ZERO27;
    endcase
  end

  dspsel_preadd
  #(
    .PREADD_MODE (PREADD_MODE)
  )
  u_preadd
  (
    .op_a   (pre_op_a),
    .op_b   (pre_op_b),
    .result (pre_out)
  );

  // Static multiplexers; the parameters never move at run time.
  always @*
  begin
    case (SEL_MULT_A)
      `DSPSEL_SEL2_0: mult_a = {a[17], a};
      `DSPSEL_SEL2_1: mult_a = pre_out[18:0];
      `DSPSEL_SEL2_2: mult_a = regfile_dout[18:0];
      default:        mult_a = {1'b0, a};
    endcase
  end

  always @*
  begin
    case (SEL_MULT_B)
      `DSPSEL_SEL2_0: mult_b = b;
      `DSPSEL_SEL2_1: mult_b = fwdi_casc;
      `DSPSEL_SEL2_2: mult_b = pre_out;
      default:        mult_b = regfile_dout;
    endcase
  end

  assign product     = $signed(mult_a) * $signed(mult_b);
  assign product_ext = {{18{product[45]}}, product};
  assign concat_abr  = {reg_addr, a, b};

  always @*
  begin
    case (SEL_ADDSUB_A)
      `DSPSEL_SEL2_0: addsub_a = product_ext;
      `DSPSEL_SEL2_1: addsub_a = product_ext << `DSPSEL_MULA_SHIFT;
      `DSPSEL_SEL2_2: addsub_a = {{16{concat_abr[47]}}, concat_abr};
      default:        addsub_a = fwdi_dout;
    endcase
  end

  always @*
  begin
    if (SEL_ADDSUB_B)
      addsub_b_sel = fwdi_dout;
    else
      addsub_b_sel = result_reg;
  end

  // The shift stands alone so that it stays signed; inside a mixed mux it would fill with zeros.
  always @*
  begin
    if (mshift)
      addsub_b = $signed(addsub_b_sel) >>> `DSPSEL_ADDB_SHIFT;
    else
      addsub_b = addsub_b_sel;
  end

  always @*
  begin
    if (sub)
      addsub_b_op = ~addsub_b;
    else
      addsub_b_op = addsub_b;
  end

  always @*
  begin
    if (SEL_CIN)
      carry_in = fwdi_cin;
    else
      carry_in = cin;
  end

  // Subtraction is A plus inverted B plus carry; a carry of one gives A minus B.
  assign sum65       = add65(addsub_a, addsub_b_op, carry_in);
  assign carry_full  = sum65[`DSPSEL_NARROW_CARRY];
  assign carry_wide  = carry48(addsub_a, addsub_b_op, carry_in);

  always @*
  begin
    if (ADDSUB_BYPASS)
      addsub_res = addsub_a;
    else
      addsub_res = sum65[63:0];
  end

  assign ovf_pos   = ~ADDSUB_BYPASS & ~addsub_a[63] & ~addsub_b_op[63] & sum65[63];
  assign ovf_neg   = ~ADDSUB_BYPASS & addsub_a[63] & addsub_b_op[63] & ~sum65[63];
  assign pat_match = (addsub_res == MATCH_PATTERN);

  always @*
  begin
    case (SEL_DOUT)
      `DSPSEL_SEL2_0: next_dout = {3'h0, addsub_res[44:0]};
      `DSPSEL_SEL2_1: next_dout = {3'h0, `DSPSEL_ZERO13, addsub_res[63:32]};
      `DSPSEL_SEL2_2: next_dout = {3'h0, `DSPSEL_ZERO13, revi_dout};
      default:        next_dout = `DSPSEL_ZERO48;
    endcase
    if (SEL_48_DOUT)
    begin
      next_dout[`DSPSEL_WIDE_LSB + 2] = ovf_pos;
      next_dout[`DSPSEL_WIDE_LSB + 1] = ovf_neg;
      next_dout[`DSPSEL_WIDE_LSB]     = pat_match;
      next_over_pos = 1'b0;
      next_over_neg = 1'b0;
      next_match    = 1'b0;
      next_cout     = carry_wide;
    end
    else
    begin
      next_over_pos = ovf_pos;
      next_over_neg = ovf_neg;
      next_match    = pat_match;
      next_cout     = carry_full;
    end
  end

  always @*
  begin
    case (SEL_FWDO_DOUT)
      `DSPSEL_SEL2_0: fwdo_dout = addsub_res;
      `DSPSEL_SEL2_1: fwdo_dout = result_reg;
      `DSPSEL_SEL2_2: fwdo_dout = fwdi_dout;
      default:        fwdo_dout = `DSPSEL_ZERO64;
    endcase
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dout       <= `DSPSEL_ZERO48;
      over_pos   <= 1'b0;
      over_neg   <= 1'b0;
      match      <= 1'b0;
      cout       <= 1'b0;
      result_reg <= `DSPSEL_ZERO64;
    end
    else
    begin
      dout       <= next_dout;
      over_pos   <= next_over_pos;
      over_neg   <= next_over_neg;
      match      <= next_match;
      cout       <= next_cout;
      result_reg <= addsub_res;
    end
  end

  // Cascade registers sit apart from the adder path and load on every edge.
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      fwdo_casc <= `DSPSEL_ZERO27;
      revo_casc <= `DSPSEL_ZERO27;
    end
    else
    begin
      fwdo_casc <= mult_b;
      // Loop-back is chosen by the configurer for a symmetric middle stage.
      revo_casc <= SEL_REVI_CASC ? fwdo_casc : revi_casc;
    end
  end

endmodule

`default_nettype wire

// File: bench/dspsel_props.sv
// Purpose: Port assertions for the slice datapath selection top.
// Assumes: Parameters mirror those of the bound instance.
// Notes:   The bind follows the module.
`timescale 1ns/1ps
`default_nettype none
module dspsel_props
#(
  parameter        SEL_REVI_CASC = 1'h0,
  parameter [1:0]  SEL_MULT_B    = 2'h0,
  parameter        ADDSUB_BYPASS = 1'h0,
  parameter [1:0]  SEL_DOUT      = 2'h0,
  parameter        SEL_48_DOUT   = 1'h0,
  parameter [1:0]  SEL_FWDO_DOUT = 2'h1,
  parameter [63:0] MATCH_PATTERN = 64'h0000_0000_0000_0000
)
(
  input wire        ref_clk,
  input wire        rst,
  input wire [26:0] b,
  input wire [26:0] fwdi_casc,
  input wire [26:0] revi_casc,
  input wire [47:0] dout,
  input wire        over_pos,
  input wire        over_neg,
  input wire        match,
  input wire [26:0] fwdo_casc,
  input wire [26:0] revo_casc,
  input wire [63:0] fwdo_dout,
  input wire [63:0] result_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rev; !$past(rst) |-> revo_casc == (SEL_REVI_CASC ? $past(fwdo_casc) : $past(revi_casc)); endproperty
  a_rev: assert property (p_rev) else $error("reverse delay register wrong");
  property p_mulb; !SEL_MULT_B[1] && !$past(rst) |-> fwdo_casc == (SEL_MULT_B[0] ? $past(fwdi_casc) : $past(b));
  endproperty
  a_mulb: assert property (p_mulb) else $error("forward cascade out wrong");
  property p_fwd; SEL_FWDO_DOUT == 2'h0 && !ADDSUB_BYPASS && !$past(rst) |-> result_reg == $past(fwdo_dout); endproperty
  a_fwd: assert property (p_fwd) else $error("unregistered cascade sum wrong");
  property p_dhi; SEL_DOUT == 2'h1 |-> dout[44:0] == {13'h0000, result_reg[63:32]}; endproperty
  a_dhi: assert property (p_dhi) else $error("upper result select wrong");
  property p_nar; !SEL_48_DOUT |-> dout[47:45] == 3'h0; endproperty
  a_nar: assert property (p_nar) else $error("narrow mode top bits set");
  property p_mat; !SEL_48_DOUT && !$past(rst) |-> match == (result_reg == MATCH_PATTERN); endproperty
  a_mat: assert property (p_mat) else $error("match flag wrong");
  property p_ovp; !SEL_48_DOUT && over_pos |-> result_reg[63]; endproperty
  a_ovp: assert property (p_ovp) else $error("positive overflow without wrap");
  property p_ovn; !SEL_48_DOUT && over_neg |-> !result_reg[63]; endproperty
  a_ovn: assert property (p_ovn) else $error("negative overflow without wrap");
  c_ovp: cover property (over_pos);
  c_ovn: cover property (over_neg);
  c_mat: cover property (match);
endmodule
bind dspsel_top dspsel_props #(.SEL_REVI_CASC(SEL_REVI_CASC), .SEL_MULT_B(SEL_MULT_B), .ADDSUB_BYPASS(ADDSUB_BYPASS),
  .SEL_DOUT(SEL_DOUT), .SEL_48_DOUT(SEL_48_DOUT), .SEL_FWDO_DOUT(SEL_FWDO_DOUT), .MATCH_PATTERN(MATCH_PATTERN)) chk
  (.ref_clk(ref_clk), .rst(rst), .b(b), .fwdi_casc(fwdi_casc), .revi_casc(revi_casc), .dout(dout), .over_pos(over_pos),
  .over_neg(over_neg), .match(match), .fwdo_casc(fwdo_casc), .revo_casc(revo_casc), .fwdo_dout(fwdo_dout),
  .result_reg(result_reg));
`default_nettype wire

// File: bench/dspsel_nbr.sv
// Purpose: Neighbouring slices on the forward and reverse cascade buses.
// Assumes: Mode 0 gives random traffic, modes 1 to 3 fixed corner words on fwdi_dout and fwdi_cin only.
// Notes:   Outputs change only at the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dspsel_nbr
#(
  parameter [31:0] SEED = 32'h047e_48f2
)
(
  input wire        ref_clk,
  input wire [1:0]  mode,
  output reg [26:0] fwdi_casc,
  output reg [26:0] revi_casc,
  output reg [63:0] fwdi_dout,
  output reg        fwdi_cin,
  output reg [31:0] revi_dout
);
  integer seed = SEED;
  initial {fwdi_casc, revi_casc, fwdi_dout, fwdi_cin, revi_dout} = 151'h0;
  always @(posedge ref_clk)
  begin
    fwdi_casc <= $random(seed);
    revi_casc <= $random(seed);
    revi_dout <= $random(seed);
    fwdi_cin  <= (mode == 2'h0) ? seed[0] : (mode == 2'h1);
    fwdi_dout <= (mode == 2'h1) ? 64'hffff_ffff_ffff_ffff : (mode == 2'h2) ? 64'h7fff_ffff_ffff_ffff :
                 (mode == 2'h3) ? 64'h8000_0000_0000_0000 : {$random(seed), $random(seed)};
  end
endmodule
`default_nettype wire

// File: bench/dsp_slice_datapath_select_bench.sv
// Purpose: Self-checking bench of the slice datapath selection top.
// Assumes: Loop-back, concatenation and cascade selects are configured.
// Notes:   Corner words force carry, match and both overflows.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin tests_run = tests_run + 1; if ((g) !== (x)) begin fails = fails + 1; \
  $display("wrong value at %0t: %h expected %h", $time, g, x); end end
module dsp_slice_datapath_select_bench;
  reg         ref_clk = 1'h0;
  reg         rst = 1'h1;
  reg         cin, sub, mshift, primed = 1'h0;
  reg  [17:0] a;
  reg  [26:0] b, regfile_dout, e_c, e_r;
  reg  [2:0]  reg_addr;
  reg  [1:0]  mode, cm;
  reg  [66:0] e;
  wire [26:0] fwdi_casc, revi_casc, fwdo_casc, revo_casc;
  wire [63:0] fwdi_dout, fwdo_dout, result_reg;
  wire [31:0] revi_dout;
  wire [47:0] dout;
  wire        fwdi_cin, over_pos, over_neg, match, cout;
  integer     fails = 0, tests_run = 0, seed = 32'h047e_48f2, cyc = 0, i;
  dspsel_nbr nbr (.ref_clk(ref_clk), .mode(mode), .fwdi_casc(fwdi_casc), .revi_casc(revi_casc),
    .fwdi_dout(fwdi_dout), .fwdi_cin(fwdi_cin), .revi_dout(revi_dout));
  dspsel_top #(.SEL_REVI_CASC(1'h1), .SEL_ADDSUB_A(2'h2), .SEL_ADDSUB_B(1'h1),
    .SEL_DOUT(2'h1), .SEL_FWDO_DOUT(2'h0)) uut (.ref_clk(ref_clk), .rst(rst), .a(a), .b(b),
    .reg_addr(reg_addr), .regfile_dout(regfile_dout), .fwdi_casc(fwdi_casc), .revi_casc(revi_casc),
    .fwdi_dout(fwdi_dout), .fwdi_cin(fwdi_cin), .revi_dout(revi_dout), .cin(cin), .sub(sub), .mshift(mshift),
    .dout(dout), .over_pos(over_pos), .over_neg(over_neg), .match(match), .cout(cout), .fwdo_casc(fwdo_casc),
    .revo_casc(revo_casc), .fwdo_dout(fwdo_dout), .result_reg(result_reg));
  // Returns overflow flags, carry-out and the 64-bit sum of A plus the shifted, optionally inverted B.
  function [66:0] exp_sum(input [63:0] x, input [63:0] f, input sh, input sb, input c);
    reg [63:0] y;
    reg [64:0] s;
    begin
      y = $signed(f) >>> (sh ? 17 : 0);
      if (sb)
        y = ~y;
      s = {1'h0, x} + {1'h0, y} + c;
      exp_sum = {~x[63] & ~y[63] & s[63], x[63] & y[63] & ~s[63], s};
    end
  endfunction
  task stop_test;
    begin
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      fails = fails + 1;
      stop_test;
    end
  end
  always @(negedge ref_clk)
    if (!rst)
    begin
      if (primed)
      begin
        `CHK(result_reg, e[63:0])
        `CHK(cout, e[64])
        `CHK({over_pos, over_neg, match}, {e[66:65], e[63:0] == 64'h0000_0000_0000_0000})
        `CHK(dout, {16'h0000, e[63:32]})
        `CHK(fwdo_casc, e_c)
        `CHK(revo_casc, e_r)
      end
      e = exp_sum({{16{reg_addr[2]}}, reg_addr, a, b}, fwdi_dout, mshift, sub, cin);
      `CHK(fwdo_dout, e[63:0])
      e_r = e_c;
      e_c = b;
      primed = 1'h1;
    end
  initial
  begin
    {a, b, reg_addr, regfile_dout, cin, sub, mshift, mode} = 80'h0;
    e_c = 27'h000_0000;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    for (i = 0; i < 600; i = i + 1)
    begin
      @(posedge ref_clk);
      // The neighbour applies the mode set one edge earlier, so operands follow it here.
      cm = mode;
      mode <= (i % 16 < 3) ? i[1:0] + 2'h1 : 2'h0;
      a <= cm ? {17'h0_0000, cm == 2'h2} : $random(seed);
      b <= cm ? 27'h000_0000 : $random(seed);
      reg_addr <= (cm == 2'h3) ? 3'h4 : cm ? 3'h0 : $random(seed);
      {sub, mshift, cin} <= cm ? {2'h0, cm == 2'h1} : $random(seed);
      regfile_dout <= $random(seed);
    end
    stop_test;
  end
endmodule
`default_nettype wire
